// >>> design/tmr_fifo.sv
// byte fifo held in flip-flops, with level count and flush
`timescale 1ns/1ps
`default_nettype none
module tmr_fifo
  import tmr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  // fill side
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_head,
  output logic [$clog2(DEPTH):0] o_count,
  output logic o_full,
  output logic o_empty
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tmr_fifo_reg_t;
  tmr_fifo_reg_t r, next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push, do_pop;

  assign o_full = (r.cnt == (AW + 1)'(DEPTH));
  assign o_empty = (r.cnt == '0);
  assign o_count = r.cnt;
  assign o_head = mem[r.rp];
  // a push while full is dropped, a pop while empty leaves the pointer
  assign do_push = i_push && !o_full;
  assign do_pop = i_pop && !o_empty;

  always_comb begin
    next_r = r;
    if (do_push) begin
      next_r.wp = r.wp + 1'b1;
    end
    if (do_pop) begin
      next_r.rp = r.rp + 1'b1;
    end
    next_r.cnt = r.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    if (i_flush) begin
      next_r = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[r.wp] <= i_data;
    end
  end
endmodule
`default_nettype wire

// >>> design/tmr_master.sv
// two-wire master: register front end, byte fifos and serial engine
// Notes on behaviour
// - writes to both length registers are dropped while a transfer runs
// - a read takes rx-length bytes into the receive fifo, then stops or holds
// - receive fifo full before the count: scl is held low until space appears
// - automatic or sequence command with zero length is refused and flagged
// - manual command with zero length sends address only, then holds scl low
// - a write sends tx-length bytes from the transmit fifo, then stops or holds
// - transmit fifo empty before the count: scl is held low until data arrives
// - first address byte bits 7:1 go first; prefix 11110 marks a ten-bit address
// - ten-bit mode sends the second address byte after the first byte's ack
// - direction bit is the eighth bit: 0 writes from tx fifo, 1 reads into rx
// - sequence command ignores the direction bit: write first, then read
// - data port write pushes a byte; dropped when the transmit fifo is full
// - data port read pops a byte; empty fifo returns head without popping
// - fifo level registers give a 4-bit count, 0 empty to 8 full
// - enables 15:4 gate status 15:4 onto the interrupt; the summary bit ORs status 15:14 and 10:4 ungated
// - status 11:4 covers the latest command; cleared by a read or a new command; 13:12 follow fifo levels
// - any enabled status bit among 15:4 raises the interrupt
// - status bit 8 flags a zero length on automatic or sequence commands
// - command codes: manual, automatic, sequence, stop, transmit flush
`timescale 1ns/1ps
`default_nettype none
module tmr_master
  import tmr_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire tmr_bus_t i_bus,
  output logic [31:0] o_rdata,
  // serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_sda_o,
  output logic o_sda_oe,
  // interrupt
  output logic o_irq
);
  typedef struct packed {
    tmr_state_t st;
    tmr_phase_t ph;
    logic [1:0] q;
    logic [15:0] div;
    logic [8:0] shtx;
    logic [8:0] shrx;
    logic [3:0] bitn;
    logic [7:0] remain;
    logic [2:0] code;
    logic dir;
    logic restart;
    logic fin_ok;
    logic stop_cmd;
    logic [7:0] rx_len;
    logic [7:0] tx_len;
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [15:0] ien;
    logic [15:4] stat;
    logic [31:0] rdata;
    logic irq;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic zero;
  } tmr_reg_t;
  tmr_reg_t r, next_r;

  logic tick, adv, busy, idle_or_hold, wr_cmd, issue, legal, ten_bit;
  logic tx_pop, rx_push, tx_flush, rx_pop, tx_full, tx_empty, rx_full, rx_empty;
  logic [7:0] tx_head, rx_head;
  logic [3:0] tx_cnt, rx_cnt;
  logic [15:4] set_bits;

  tmr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_flush(tx_flush),
    .i_push(i_bus.wr && i_bus.addr == OFF_DATA), .i_data(i_bus.wdata[7:0]),
    .i_pop(tx_pop), .o_head(tx_head), .o_count(tx_cnt), .o_full(tx_full), .o_empty(tx_empty)
  );
  tmr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxf (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_flush(1'b0),
    .i_push(rx_push), .i_data(r.shrx[8:1]),
    .i_pop(rx_pop), .o_head(rx_head), .o_count(rx_cnt), .o_full(rx_full), .o_empty(rx_empty)
  );

  // quarter-bit enable; stall while a target stretches scl low
  assign tick = (r.div == 16'(QUARTER - 1));
  assign adv = tick && !(r.q == 2'h2 && !r.scl_sync[1]);
  assign idle_or_hold = (r.st == S_IDLE) || (r.st == S_HOLD);
  assign busy = !idle_or_hold;
  assign ten_bit = (r.addr1[7:3] == TEN_BIT_PREFIX);
  assign wr_cmd = i_bus.wr && i_bus.addr == OFF_COMMAND && i_bus.wdata[CMD_ISSUE_POS];
  assign legal = (i_bus.wdata[2:0] <= CMD_STOP) || (i_bus.wdata[2:0] == CMD_FLUSH);
  assign issue = wr_cmd && legal && !busy;
  assign rx_pop = i_bus.rd && i_bus.addr == OFF_DATA;
  assign tx_flush = issue && i_bus.wdata[2:0] == CMD_FLUSH;
  assign o_scl_o = r.zero;
  assign o_sda_o = r.zero;
  assign o_scl_oe = r.scl_oe;
  assign o_sda_oe = r.sda_oe;
  assign o_rdata = r.rdata;
  assign o_irq = r.irq;

  always_comb begin
    next_r = r;
    set_bits = '0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    next_r.zero = 1'b0;
    next_r.scl_sync = {r.scl_sync[0], i_scl};
    next_r.sda_sync = {r.sda_sync[0], i_sda};
    next_r.div = tick ? 16'h0000 : r.div + 16'h0001;
    // register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        OFF_RX_LEN: if (!busy) next_r.rx_len = i_bus.wdata[7:0];
        OFF_TX_LEN: if (!busy) next_r.tx_len = i_bus.wdata[7:0];
        OFF_ADDR1: next_r.addr1 = i_bus.wdata[7:0];
        OFF_ADDR2: next_r.addr2 = i_bus.wdata[7:0];
        OFF_IRQ_EN: next_r.ien = i_bus.wdata[15:0];
        default: next_r.zero = 1'b0;
      endcase
    end
    // command issue
    if (issue) begin
      next_r.code = i_bus.wdata[2:0];
      next_r.restart = 1'b0;
      next_r.stop_cmd = 1'b0;
      next_r.fin_ok = 1'b0;
      next_r.q = 2'h0;
      unique case (i_bus.wdata[2:0])
        CMD_STOP: begin
          if (r.st == S_HOLD) begin
            next_r.st = S_STOP;
            next_r.stop_cmd = 1'b1;
          end else begin
            set_bits[ST_STOP_CMD] = 1'b1;
          end
        end
        CMD_FLUSH: next_r.zero = 1'b0;
        default: begin
          next_r.dir = (i_bus.wdata[2:0] == CMD_SEQ) ? 1'b0 : r.addr1[0];
          next_r.remain = next_r.dir ? r.rx_len : r.tx_len;
          if (i_bus.wdata[2:0] != CMD_MANUAL && (next_r.remain == 8'h00 ||
              (i_bus.wdata[2:0] == CMD_SEQ && r.rx_len == 8'h00))) begin
            set_bits[ST_BAD_LEN] = 1'b1;
          end else begin
            next_r.st = S_START;
          end
        end
      endcase
    end
    // serial engine
    unique case (r.st)
      S_IDLE: begin
        next_r.scl_oe = 1'b0;
        next_r.sda_oe = 1'b0;
      end
      S_HOLD: next_r.scl_oe = 1'b1;
      S_START: if (adv) begin
        next_r.q = r.q + 2'h1;
        unique case (r.q)
          2'h0: next_r.sda_oe = 1'b0;
          2'h1: next_r.scl_oe = 1'b0;
          2'h2: next_r.sda_oe = 1'b1;
          default: begin
            next_r.scl_oe = 1'b1;
            next_r.st = S_BIT;
            next_r.ph = P_ADDR1;
            next_r.bitn = 4'h0;
            next_r.shtx = {r.addr1[7:1], r.dir, 1'b1};
          end
        endcase
      end
      S_BIT: if (adv) begin
        next_r.q = r.q + 2'h1;
        unique case (r.q)
          2'h0: next_r.sda_oe = !r.shtx[8];
          2'h1: next_r.scl_oe = 1'b0;
          2'h2: next_r.shrx = {r.shrx[7:0], r.sda_sync[1]};
          default: begin
            next_r.scl_oe = 1'b1;
            next_r.shtx = {r.shtx[7:0], 1'b1};
            next_r.bitn = r.bitn + 4'h1;
            if (r.bitn == 4'h8) begin
              next_r.st = S_NEXT;
              unique case (r.ph)
                P_ADDR1: begin
                  if (r.shrx[0]) begin
                    set_bits[ST_NAK_ADDR] = 1'b1;
                    next_r.st = S_STOP;
                  end else if (ten_bit && !r.restart) begin
                    next_r.st = S_BIT;
                    next_r.ph = P_ADDR2;
                    next_r.bitn = 4'h0;
                    next_r.shtx = {r.addr2, 1'b1};
                  end
                end
                P_ADDR2: if (r.shrx[0]) begin
                  set_bits[ST_NAK_ADDR] = 1'b1;
                  next_r.st = S_STOP;
                end
                P_WDATA: begin
                  next_r.remain = r.remain - 8'h01;
                  if (r.shrx[0]) begin
                    set_bits[ST_NAK_DATA] = 1'b1;
                    next_r.st = S_STOP;
                  end
                end
                default: begin
                  rx_push = 1'b1;
                  next_r.remain = r.remain - 8'h01;
                end
              endcase
            end
          end
        endcase
      end
      S_NEXT: begin
        next_r.sda_oe = 1'b0;
        next_r.q = 2'h0;
        if (r.remain == 8'h00) begin
          if (r.code == CMD_SEQ && !r.restart) begin
            next_r.restart = 1'b1;
            next_r.dir = 1'b1;
            next_r.remain = r.rx_len;
            next_r.st = S_START;
          end else if (r.code == CMD_MANUAL) begin
            set_bits[ST_DONE_HOLD] = 1'b1;
            next_r.st = S_HOLD;
          end else begin
            next_r.fin_ok = 1'b1;
            next_r.st = S_STOP;
          end
        end else if (!r.dir) begin
          if (!tx_empty) begin
            tx_pop = 1'b1;
            next_r.shtx = {tx_head, 1'b1};
            next_r.ph = P_WDATA;
            next_r.bitn = 4'h0;
            next_r.st = S_BIT;
          end
        end else if (!rx_full) begin
          next_r.shtx = {8'hff, r.remain == 8'h01};
          next_r.ph = P_RDATA;
          next_r.bitn = 4'h0;
          next_r.st = S_BIT;
        end
      end
      default: if (adv) begin // stop condition
        next_r.q = r.q + 2'h1;
        unique case (r.q)
          2'h0: next_r.sda_oe = 1'b1;
          2'h1: next_r.scl_oe = 1'b0;
          2'h2: next_r.sda_oe = 1'b0;
          default: begin
            set_bits[ST_STOP_CMD] = r.stop_cmd;
            set_bits[ST_DONE_STOP] = r.fin_ok;
            next_r.st = S_IDLE;
          end
        endcase
      end
    endcase
    // status: read or new command clears, a same-cycle event still lands
    if (issue || (i_bus.rd && i_bus.addr == OFF_IRQ_STAT)) begin
      next_r.stat = '0;
    end
    next_r.stat = next_r.stat | set_bits;
    next_r.stat[ST_RX_HIGH] = (r.ph == P_RDATA) && busy && rx_cnt >= RX_HIGH_MARK &&
      r.remain > 8'(4'(FIFO_DEPTH) - rx_cnt);
    next_r.stat[ST_TX_LOW] = !r.dir && busy && tx_cnt <= TX_LOW_MARK && r.remain > 8'(tx_cnt);
    next_r.irq = |(r.stat & r.ien[15:4]);
    // register reads, data one cycle after the strobe
    next_r.rdata = 32'h0000_0000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        OFF_COMMAND: next_r.rdata = {28'h0, busy, r.code};
        OFF_RX_LEN: next_r.rdata = {24'h0, r.rx_len};
        OFF_TX_LEN: next_r.rdata = {24'h0, r.tx_len};
        OFF_ADDR1: next_r.rdata = {24'h0, r.addr1};
        OFF_ADDR2: next_r.rdata = {24'h0, r.addr2};
        OFF_DATA: next_r.rdata = {24'h0, rx_head};
        OFF_TX_LEVEL: next_r.rdata = {28'h0, tx_cnt};
        OFF_RX_LEVEL: next_r.rdata = {28'h0, rx_cnt};
        OFF_IRQ_EN: next_r.rdata = {16'h0, r.ien};
        OFF_IRQ_STAT: next_r.rdata = {15'h0, r.irq, r.stat, |{r.stat[15:14], r.stat[10:4]},
          r.code == CMD_SEQ && busy, busy && !r.dir, busy && r.dir};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r <= '0;
      r.st <= S_IDLE;
      r.ph <= P_ADDR1;
      r.rx_len <= RST_LEN;
      r.tx_len <= RST_LEN;
      r.addr1 <= RST_ADDR;
      r.addr2 <= RST_ADDR;
      r.ien <= RST_IEN;
      r.scl_sync <= 2'h3;
      r.sda_sync <= 2'h3;
    end else begin
      r <= next_r;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_len_write_lock: assert property (busy && $past(busy) ##0 $stable(r.rx_len) or !busy or !$past(busy))
    else $error("length changed during transfer");
  a_rx_depth_max: assert property (rx_cnt <= 4'h8 && tx_cnt <= 4'h8)
    else $error("fifo level out of range");
  a_tx_full_drop: assert property (tx_full && !tx_pop ##0 i_bus.wr && i_bus.addr == OFF_DATA
    |=> tx_full)
    else $error("write to full fifo changed level");
  a_bad_length_flag: assert property (issue && i_bus.wdata[2:0] == CMD_AUTO
    && (r.addr1[0] ? r.rx_len : r.tx_len) == 8'h00 |=> r.stat[ST_BAD_LEN] && !busy)
    else $error("zero length not flagged");
  a_status_read_clear: assert property (i_bus.rd && i_bus.addr == OFF_IRQ_STAT && !issue && set_bits == '0
    && r.st != S_STOP |=> r.stat[11:4] == '0)
    else $error("status not cleared by read");
  a_irq_follow: assert property (|(r.stat & r.ien[15:4]) |=> o_irq)
    else $error("interrupt missing");
  a_hold_scl_low: assert property (r.st == S_HOLD ##1 r.st == S_HOLD |-> o_scl_oe)
    else $error("scl released while holding");
  a_rx_wait_low: assert property (r.st == S_NEXT && r.dir && rx_full && r.remain != 8'h00
    |=> r.st == S_NEXT && o_scl_oe)
    else $error("read continued with full fifo");
  a_tx_wait_low: assert property (r.st == S_NEXT && !r.dir && tx_empty && r.remain != 8'h00
    |=> r.st == S_NEXT && o_scl_oe)
    else $error("write continued with empty fifo");
  a_seq_dir: assert property (issue && i_bus.wdata[2:0] == CMD_SEQ && r.st == S_IDLE && r.tx_len != 8'h00
    && r.rx_len != 8'h00 |=> !r.dir)
    else $error("sequence did not begin with a write");
endmodule
`default_nettype wire

// >>> design/tmr_pkg.sv
// package: register map, field layout, states and carriers of the two-wire master front end
package tmr_pkg;
  // register byte offsets
  localparam logic [15:0] OFF_COMMAND = 16'h4050;
  localparam logic [15:0] OFF_RX_LEN = 16'h4058;
  localparam logic [15:0] OFF_TX_LEN = 16'h4060;
  localparam logic [15:0] OFF_ADDR1 = 16'h4068;
  localparam logic [15:0] OFF_ADDR2 = 16'h4070;
  localparam logic [15:0] OFF_DATA = 16'h4078;
  localparam logic [15:0] OFF_TX_LEVEL = 16'h4080;
  localparam logic [15:0] OFF_RX_LEVEL = 16'h4088;
  localparam logic [15:0] OFF_IRQ_EN = 16'h4090;
  localparam logic [15:0] OFF_IRQ_STAT = 16'h4098;
  // reset values
  localparam logic [7:0] RST_LEN = 8'h00;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [15:0] RST_IEN = 16'h0000;
  // command register fields
  localparam int CMD_ISSUE_POS = 3;
  localparam logic [2:0] CMD_MANUAL = 3'h0;
  localparam logic [2:0] CMD_AUTO = 3'h1;
  localparam logic [2:0] CMD_SEQ = 3'h2;
  localparam logic [2:0] CMD_STOP = 3'h3;
  localparam logic [2:0] CMD_FLUSH = 3'h7;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  // status bit positions
  localparam int ST_RX_HIGH = 13;
  localparam int ST_TX_LOW = 12;
  localparam int ST_DONE_HOLD = 11;
  localparam int ST_DONE_STOP = 10;
  localparam int ST_STOP_CMD = 9;
  localparam int ST_BAD_LEN = 8;
  localparam int ST_NAK_DATA = 5;
  localparam int ST_NAK_ADDR = 4;
  localparam int ST_SUMMARY = 16;
  localparam logic [3:0] RX_HIGH_MARK = 4'h4;
  localparam logic [3:0] TX_LOW_MARK = 4'h3;
  // fifo geometry and serial timing
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_START = 6'h02,
    S_BIT = 6'h04,
    S_NEXT = 6'h08,
    S_STOP = 6'h10,
    S_HOLD = 6'h20
  } tmr_state_t;

  typedef enum logic [3:0] {
    P_ADDR1 = 4'h1,
    P_ADDR2 = 4'h2,
    P_WDATA = 4'h4,
    P_RDATA = 4'h8
  } tmr_phase_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tmr_bus_t;
endpackage

// >>> verif/tb.sv
// self-checking testbench of the two-wire master front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  localparam logic [6:0] DEV = 7'h52;
  localparam logic [31:0] IEN = 32'h0f30;
  typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} tmr_row_t;
  tmr_row_t rows [7] = '{'{OFF_RX_LEN, 32'h1ff, 32'hff}, '{OFF_TX_LEN, 32'h5a, 32'h5a},
    '{OFF_ADDR1, 32'hab, 32'hab}, '{OFF_ADDR2, 32'h133, 32'h33}, '{OFF_IRQ_EN, 32'hffffffff, 32'hffff},
    '{OFF_TX_LEVEL, 32'h7, 32'h0}, '{16'h40f0, 32'h1, 32'h0}};
  logic [15:0] offs [8] = '{OFF_RX_LEN, OFF_TX_LEN, OFF_ADDR1, OFF_ADDR2, OFF_TX_LEVEL, OFF_RX_LEVEL,
    OFF_IRQ_EN, OFF_IRQ_STAT};
  logic i_clk, i_sys_rst, scl, sda, m_oe, o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_irq;
  logic [31:0] o_rdata, v;
  tmr_bus_t bus;
  int n_mismatch, n_checks;
  tmr_master #(.QUARTER(4)) i_tmr_master (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus),
    .o_rdata(o_rdata), .i_scl(scl), .i_sda(sda), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_irq(o_irq));
  tmr_eeprom_model #(.DEV(DEV)) i_tmr_eeprom_model (.i_scl(scl), .i_sda(sda), .o_sda_oe(m_oe));
  // both wires have pull-ups
  assign scl = o_scl_oe ? o_scl_o : 1'b1;
  assign sda = (o_sda_oe || m_oe) ? 1'b0 : 1'b1;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  // write strobe stays up until the next task changes the bus
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
  endtask
  task automatic rdv(input logic [15:0] a);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    @(posedge i_clk);
    v = o_rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string nm);
    rdv(a);
    chk(nm, v, e);
  endtask
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wirq();
    int k;
    k = 0;
    bus <= '0;
    while (o_irq !== 1'b1 && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    chk("irq", 32'(o_irq), 32'h1);
  endtask
  task automatic wlog(input int n);
    int k;
    k = 0;
    bus <= '0;
    while (i_tmr_eeprom_model.n_log < n && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
  endtask
  task automatic cmd(input logic [2:0] c);
    wr(OFF_COMMAND, {28'h0, 1'b1, c});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // whole run needs well under 10k cycles
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    i_sys_rst = 1'b1;
    bus = '0;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rdc(rows[k].a, rows[k].e, "register");
    end
    // live threshold bits stay masked so waits see only completions
    wr(OFF_IRQ_EN, IEN);
    wr(OFF_ADDR1, {24'h0, DEV, 1'b0});
    wr(OFF_TX_LEN, 32'h2);
    wr(OFF_DATA, 32'ha5);
    cmd(CMD_MANUAL);
    wlog(2);
    idle(40);
    chk("scl held", 32'(o_scl_oe), 32'h1);
    chk("bytes", i_tmr_eeprom_model.n_log, 32'h2);
    wr(OFF_TX_LEN, 32'h77);
    wr(OFF_DATA, 32'h3c);
    wirq();
    rdc(OFF_IRQ_STAT, 32'h10800, "status");
    rdc(OFF_IRQ_STAT, 32'h0, "status");
    rdc(OFF_TX_LEN, 32'h2, "tx len");
    chk("addr", 32'(i_tmr_eeprom_model.log_b[0]), {24'h0, DEV, 1'b0});
    chk("data", 32'(i_tmr_eeprom_model.log_b[1]), 32'ha5);
    chk("data", 32'(i_tmr_eeprom_model.log_b[2]), 32'h3c);
    cmd(CMD_STOP);
    wirq();
    rdc(OFF_IRQ_STAT, 32'h10208, "status");
    idle(100);
    chk("lines", {30'h0, o_scl_oe, o_sda_oe}, 32'h0);
    // read of 10 bytes overruns the 8-byte receive fifo
    wr(OFF_ADDR1, {24'h0, DEV, 1'b1});
    wr(OFF_RX_LEN, 32'ha);
    cmd(CMD_AUTO);
    v = 0;
    for (int k = 0; k < 600 && v !== 32'h8; k++) rdv(OFF_RX_LEVEL);
    idle(200);
    chk("scl held", 32'(o_scl_oe), 32'h1);
    rdc(OFF_RX_LEVEL, 32'h8, "rx level");
    for (int k = 0; k < 8; k++) rdc(OFF_DATA, 32'h82 + k, "rx data");
    wirq();
    rdv(OFF_IRQ_STAT);
    chk("done stop", v & 32'h400, 32'h400);
    for (int k = 8; k < 10; k++) rdc(OFF_DATA, 32'h82 + k, "rx data");
    rdv(OFF_DATA);
    rdc(OFF_RX_LEVEL, 32'h0, "rx level");
    wr(OFF_RX_LEN, 32'h0);
    wr(OFF_IRQ_EN, IEN & 32'hfeff);
    cmd(CMD_AUTO);
    idle(20);
    chk("irq masked", 32'(o_irq), 32'h0);
    rdc(OFF_IRQ_STAT, 32'h108, "status");
    wr(OFF_IRQ_EN, IEN);
    wr(OFF_TX_LEN, 32'h0);
    cmd(CMD_SEQ);
    wirq();
    rdc(OFF_IRQ_STAT, 32'h10108, "status");
    chk("bytes", i_tmr_eeprom_model.n_log, 32'h4);
    // sequence ignores the stored read direction
    wr(OFF_TX_LEN, 32'h1);
    wr(OFF_RX_LEN, 32'h1);
    wr(OFF_DATA, 32'h11);
    cmd(CMD_SEQ);
    wirq();
    rdv(OFF_IRQ_STAT);
    chk("done stop", v & 32'h400, 32'h400);
    chk("addr", 32'(i_tmr_eeprom_model.log_b[4]), {24'h0, DEV, 1'b0});
    chk("data", 32'(i_tmr_eeprom_model.log_b[5]), 32'h11);
    chk("addr", 32'(i_tmr_eeprom_model.log_b[6]), {24'h0, DEV, 1'b1});
    rdc(OFF_DATA, 32'h8d, "rx data");
    wr(OFF_ADDR1, 32'hf2);
    wr(OFF_ADDR2, 32'h33);
    wr(OFF_TX_LEN, 32'h0);
    cmd(CMD_MANUAL);
    wirq();
    rdv(OFF_IRQ_STAT);
    chk("done hold", v & 32'h800, 32'h800);
    chk("addr", 32'(i_tmr_eeprom_model.log_b[7]), 32'hf2);
    chk("addr", 32'(i_tmr_eeprom_model.log_b[8]), 32'h33);
    chk("bytes", i_tmr_eeprom_model.n_log, 32'h9);
    cmd(CMD_STOP);
    wirq();
    for (int k = 0; k < 9; k++) wr(OFF_DATA, 32'(k));
    rdc(OFF_TX_LEVEL, 32'h8, "tx level");
    cmd(CMD_FLUSH);
    rdc(OFF_TX_LEVEL, 32'h0, "tx level");
    i_sys_rst <= 1'b1;
    idle(3);
    i_sys_rst <= 1'b0;
    idle(1);
    foreach (offs[k]) rdc(offs[k], 32'h0, "reset value");
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> verif/tmr_eeprom_model.sv
// serial eeprom target model on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tmr_eeprom_model #(
  parameter logic [6:0] DEV = 7'h52
) (
  // bus wires
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe
);
  logic [7:0] mem [0:255];
  logic [7:0] log_b [0:31];
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  logic rd, ack, act, first;
  int bitn, n_log, ptr;
  initial begin
    o_sda_oe = 1'b0;
    act = 1'b0;
    n_log = 0;
    ptr = 0;
    for (int k = 0; k < 256; k++) mem[k] = 8'(8'h80 + k);
  end
  // start and stop: sda moves while scl is high
  always @(negedge i_sda) if (i_scl) begin
    act = 1'b1;
    first = 1'b1;
    bitn = 0;
    o_sda_oe = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) act = 1'b0;
  always @(posedge i_scl) if (act) begin
    if (bitn < 8) sh_in = {sh_in[6:0], i_sda};
    else if (rd && !first && i_sda) act = 1'b0;
    bitn++;
  end
  // sda only changes while scl is low
  always @(negedge i_scl) if (act) begin
    o_sda_oe = 1'b0;
    if (bitn == 8 && (first || !rd)) begin
      log_b[n_log] = sh_in;
      n_log++;
      if (first) begin
        rd = sh_in[0];
        ack = (sh_in[7:1] == DEV) || (sh_in[7:3] == 5'h1e);
      end else begin
        mem[ptr] = sh_in;
        ptr++;
      end
      o_sda_oe = ack;
    end else if (bitn == 9) begin
      first = 1'b0;
      bitn = 0;
      if (!ack) act = 1'b0;
      else if (rd) begin
        sh_out = mem[ptr];
        ptr++;
        o_sda_oe = ~sh_out[7];
      end
    end else if (rd && !first && bitn < 8) o_sda_oe = ~sh_out[7-bitn];
  end
endmodule
`default_nettype wire
